// ### tsfi_regs.svh
// Purpose: register indices, field positions, reset values and timing
//          constants of the slot scheduling and test-pattern block
// Assumes: byte address of a register is four times its index
// Notes:   one tick is a quarter bit at the fastest highway rate
`ifndef TSFI_REGS_SVH
`define TSFI_REGS_SVH

`define TSFI_IDX_GENERAL_CMD 14'h0000
`define TSFI_IDX_TEST_CMD 14'h0009
`define TSFI_IDX_PATTERN_STYLE 14'h000a
`define TSFI_IDX_PATTERN_USER 14'h0012
`define TSFI_IDX_STATUS 14'h0020
`define TSFI_IDX_SUBST_COUNT 14'h0021
`define TSFI_IDX_TXHW_BASE 14'h1002
`define TSFI_TXHW_STEP_LOG2 2

`define TSFI_GCMD_GTXE_BIT 0
`define TSFI_TCMD_START_BIT 7
`define TSFI_TCMD_RATE_LSB 4
`define TSFI_PSTYLE_SEL_LSB 4
`define TSFI_TXHW_EN_BIT 2
`define TSFI_REG_RESET 8'h00

`define TSFI_SUBST_CODE 3'b110
`define TSFI_IDLE_BYTE 8'hff

`define TSFI_FRAME_US 125
`define TSFI_FI_MAX_DELAY_US 378
`define TSFI_TICK_PS_X10 305176
`define TSFI_FI_NEAR_PS 3906250
`define TSFI_FI_FAR_PS 121093750
`define TSFI_FI_NEAR_TICKS ((`TSFI_FI_NEAR_PS * 10 + `TSFI_TICK_PS_X10 / 2) / `TSFI_TICK_PS_X10)
`define TSFI_FI_FAR_TICKS ((`TSFI_FI_FAR_PS * 10 + `TSFI_TICK_PS_X10 / 2) / `TSFI_TICK_PS_X10)
`define TSFI_LL_BASE_TICKS 4
`define TSFI_LL_RX_SLOTS 2
`define TSFI_LFSR_SEED 23'h7fffff

`endif

// ### tsfi_pkg.sv
// Purpose: types shared by the scheduling block and its pattern generator
// Assumes: rate code 0 = 2.048, 1 = 4.096, 2 = 8.192 Mbit/s
// Notes:   offsets are 12-bit tick counts, 4096 ticks to a frame
package tsfi_pkg;

    typedef struct packed {
        logic valid;
        logic [4:0] tx_hw;
        logic [6:0] tx_slot;
        logic [1:0] tx_rate;
        logic [11:0] tx_off;
        logic [6:0] rx_slot;
        logic [1:0] rx_rate;
        logic [11:0] rx_off;
        logic [2:0] slot_source_mode;
        logic frame_integrity;
        logic [7:0] data;
    } tsfi_req_t;

    typedef struct packed {
        logic valid;
        logic [4:0] tx_hw;
        logic [6:0] tx_slot;
        logic [7:0] data;
        logic drive;
        logic pattern;
        logic [1:0] frame_delay;
    } tsfi_resp_t;

    typedef struct packed {
        logic [7:0] general_command_reg;
        logic [7:0] test_command_reg;
        logic [7:0] pattern_style_reg;
        logic [7:0] pattern_user_byte_reg;
        logic [31:0] highway_tx_enable_reg;
        logic [15:0] subst_count_reg;
        logic [1:0] last_fi_delay_reg;
        logic pready_reg;
        logic pslverr_reg;
        logic [31:0] prdata_reg;
        tsfi_resp_t resp_reg;
    } tsfi_state_t;

    typedef struct packed {
        logic [22:0] lfsr_reg;
    } tsfi_gen_state_t;

endpackage : tsfi_pkg

// ### tsfi_patgen.sv
// Purpose: test-pattern source, one byte per marked slot
// Assumes: select codes 0 to 14 valid; code 15 sends zeros
// Notes:   sequence held at seed while not running
`timescale 1ns/1ns
`include "tsfi_regs.svh"
module tsfi_patgen
    import tsfi_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic advance,
    input wire logic [3:0] gen_pattern_select,
    input wire logic [7:0] user_byte,
    output logic [7:0] pattern_byte
);

    tsfi_gen_state_t st_reg;
    tsfi_gen_state_t st_next;
    logic [4:0] tap_a;
    logic [4:0] tap_b;
    logic prbs;

    // eight shifts per byte, feedback from the two taps
    function automatic logic [22:0] step8(input logic [22:0] s, input logic [4:0] a,
                                          input logic [4:0] b);
        logic [22:0] v;
        v = s;
        for (int k = 0; k < 8; k++) begin
            v = {v[21:0], v[a - 5'd1] ^ v[b - 5'd1]};
        end
        return v;
    endfunction : step8

    always_comb begin
        prbs = 1'b1;
        tap_a = 5'd7;
        tap_b = 5'd6;
        unique case (gen_pattern_select)
            4'h6: begin tap_a = 5'd7; tap_b = 5'd6; end
            4'h7: begin tap_a = 5'd9; tap_b = 5'd5; end
            4'h8: begin tap_a = 5'd11; tap_b = 5'd9; end
            4'h9: begin tap_a = 5'd15; tap_b = 5'd14; end
            4'ha: begin tap_a = 5'd20; tap_b = 5'd17; end
            4'hb: begin tap_a = 5'd20; tap_b = 5'd3; end
            4'hc: begin tap_a = 5'd23; tap_b = 5'd18; end
            4'hd: begin tap_a = 5'd6; tap_b = 5'd5; end
            4'he: begin tap_a = 5'd10; tap_b = 5'd7; end
            default: prbs = 1'b0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        if (!run) begin
            st_next.lfsr_reg = `TSFI_LFSR_SEED;
        end else if (advance && prbs) begin
            st_next.lfsr_reg = step8(st_reg.lfsr_reg, tap_a, tap_b);
        end
    end

    always_comb begin
        unique case (gen_pattern_select)
            4'h0: pattern_byte = user_byte;
            4'h1: pattern_byte = 8'h00;
            4'h2: pattern_byte = 8'hff;
            4'h3: pattern_byte = 8'h55;
            4'h4: pattern_byte = 8'haa;
            4'h5: pattern_byte = 8'h0f;
            4'hf: pattern_byte = 8'h00;
            default: pattern_byte = st_reg.lfsr_reg[7:0];
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{lfsr_reg: `TSFI_LFSR_SEED};
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : tsfi_patgen

// ### tsfi_sched.sv
// Purpose: transmit frame choice, test-pattern substitution and
//          transmit gating for one slot request per cycle, with APB registers
// Assumes: requests come from the slot sequencer with both highway offsets
// Notes:   answer is registered one cycle after the request
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "tsfi_regs.svh"
module tsfi_sched
    import tsfi_pkg::*;
#(
    parameter int NUM_HW = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tsfi_req_t slot_req,
    output tsfi_resp_t slot_resp
);

    localparam logic [13:0] NEAR_TICKS = 14'(`TSFI_FI_NEAR_TICKS);
    localparam logic [13:0] FAR_TICKS = 14'(`TSFI_FI_FAR_TICKS);

    tsfi_state_t st_reg;
    tsfi_state_t st_next;

    logic [13:0] reg_idx;
    logic [13:0] hw_rel;
    logic hw_hit;
    logic [4:0] hw_sel;
    logic word_ok;
    logic setup_phase;
    logic access_phase;
    logic [31:0] rd_word;
    logic rd_hit;

    logic gen_run;
    logic gen_advance;
    logic [7:0] gen_byte;

    logic signed [13:0] off_diff;
    logic [1:0] fi_delay;
    logic [14:0] tx_pos;
    logic [14:0] rx_need;
    logic [1:0] ll_delay;
    logic subst;
    logic hw_on;

    // start position of a slot in ticks: slot times ticks per slot
    function automatic logic [14:0] slot_ticks_at(input logic [6:0] slot,
                                                  input logic [1:0] rate);
        logic [14:0] s;
        s = {8'h00, slot};
        unique case (rate)
            2'd0: return s << 7;
            2'd1: return s << 6;
            default: return s << 5;
        endcase
    endfunction : slot_ticks_at

    function automatic logic [14:0] one_slot(input logic [1:0] rate);
        unique case (rate)
            2'd0: return 15'd128;
            2'd1: return 15'd64;
            default: return 15'd32;
        endcase
    endfunction : one_slot

    // register decode; the bus carries byte addresses of word registers
    always_comb begin
        reg_idx = paddr[15:2];
        word_ok = (paddr[1:0] == 2'b00);
        hw_rel = reg_idx - `TSFI_IDX_TXHW_BASE;
        hw_hit = word_ok && (reg_idx >= `TSFI_IDX_TXHW_BASE) && (hw_rel[1:0] == 2'b00)
                 && (hw_rel < 14'(NUM_HW * 4));
        hw_sel = hw_rel[6:2];
        setup_phase = psel && !penable;
        access_phase = psel && penable && st_reg.pready_reg;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (hw_hit) begin
            rd_word[`TSFI_TXHW_EN_BIT] = st_reg.highway_tx_enable_reg[hw_sel];
        end else if (!word_ok) begin
            rd_hit = 1'b0;
        end else begin
            unique case (reg_idx)
                `TSFI_IDX_GENERAL_CMD: rd_word[7:0] = st_reg.general_command_reg;
                `TSFI_IDX_TEST_CMD: rd_word[7:0] = st_reg.test_command_reg;
                `TSFI_IDX_PATTERN_STYLE: rd_word[7:0] = st_reg.pattern_style_reg;
                `TSFI_IDX_PATTERN_USER: rd_word[7:0] = st_reg.pattern_user_byte_reg;
                `TSFI_IDX_STATUS: begin
                    rd_word[1:0] = st_reg.last_fi_delay_reg;
                    rd_word[2] = gen_run;
                    rd_word[15:8] = gen_byte;
                end
                `TSFI_IDX_SUBST_COUNT: rd_word[15:0] = st_reg.subst_count_reg;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // frame-integrity frame choice: offsets only, slot positions play no part
    always_comb begin
        // full 12-bit offsets on both sides, so the difference spans a frame either way
        off_diff = $signed({2'b00, slot_req.tx_off}) - $signed({2'b00, slot_req.rx_off});
        if (off_diff >= $signed(NEAR_TICKS)) begin
            fi_delay = 2'd1;
        end else if (off_diff < -$signed(FAR_TICKS)) begin
            // exact edges; the allowed one-slot wander is not modelled
            fi_delay = 2'd3;
        end else begin
            fi_delay = 2'd2;
        end
    end

    // low latency: now only if the tx slot trails by two rx slots plus the highway guard
    always_comb begin
        tx_pos = slot_ticks_at(slot_req.tx_slot, slot_req.tx_rate) + {3'b000, slot_req.tx_off};
        rx_need = slot_ticks_at(slot_req.rx_slot, slot_req.rx_rate)
                  + {3'b000, slot_req.rx_off}
                  + 15'(`TSFI_LL_RX_SLOTS * one_slot(slot_req.rx_rate))
                  + 15'(`TSFI_LL_BASE_TICKS)
                  + {10'h000, slot_req.tx_hw};
        ll_delay = (tx_pos >= rx_need) ? 2'd0 : 2'd1;
    end

    always_comb begin
        gen_run = st_reg.test_command_reg[`TSFI_TCMD_START_BIT];
        subst = slot_req.valid && (slot_req.slot_source_mode == `TSFI_SUBST_CODE);
        // one stream serves every marked slot; relies on a single contiguous run
        gen_advance = subst && gen_run;
        hw_on = st_reg.highway_tx_enable_reg[slot_req.tx_hw]
                && st_reg.general_command_reg[`TSFI_GCMD_GTXE_BIT];
    end

    tsfi_patgen u_patgen (
        .core_clk(core_clk),
        .nrst(nrst),
        .run(gen_run),
        .advance(gen_advance),
        .gen_pattern_select(st_reg.pattern_style_reg[`TSFI_PSTYLE_SEL_LSB +: 4]),
        .user_byte(st_reg.pattern_user_byte_reg),
        .pattern_byte(gen_byte)
    );

    always_comb begin
        st_next = st_reg;

        // zero-wait slave: pready raised for the access cycle only
        st_next.pready_reg = setup_phase;
        if (setup_phase) begin
            st_next.prdata_reg = pwrite ? 32'h0000_0000 : rd_word;
            st_next.pslverr_reg = !rd_hit || (pwrite && (reg_idx == `TSFI_IDX_STATUS
                                  || reg_idx == `TSFI_IDX_SUBST_COUNT));
        end else begin
            // error and read data stand only beside pready
            st_next.pslverr_reg = 1'b0;
            st_next.prdata_reg = 32'h0000_0000;
        end

        if (access_phase && pwrite && !st_reg.pslverr_reg) begin
            if (hw_hit) begin
                st_next.highway_tx_enable_reg[hw_sel] = pwdata[`TSFI_TXHW_EN_BIT];
            end else begin
                unique case (reg_idx)
                    `TSFI_IDX_GENERAL_CMD: st_next.general_command_reg = pwdata[7:0];
                    `TSFI_IDX_TEST_CMD: st_next.test_command_reg = pwdata[7:0];
                    `TSFI_IDX_PATTERN_STYLE: st_next.pattern_style_reg = pwdata[7:0];
                    `TSFI_IDX_PATTERN_USER: st_next.pattern_user_byte_reg = pwdata[7:0];
                    default: st_next.pattern_user_byte_reg = st_reg.pattern_user_byte_reg;
                endcase
            end
        end

        // slot answer
        st_next.resp_reg.valid = slot_req.valid;
        st_next.resp_reg.tx_hw = slot_req.tx_hw;
        st_next.resp_reg.tx_slot = slot_req.tx_slot;
        st_next.resp_reg.pattern = subst;
        st_next.resp_reg.drive = slot_req.valid && hw_on;
        // per-slot choice of treatment; the pair shares one delay
        st_next.resp_reg.frame_delay = slot_req.frame_integrity ? fi_delay
                                                                : ll_delay;
        if (!(slot_req.valid && hw_on)) begin
            st_next.resp_reg.data = 8'h00;
        end else if (subst) begin
            // idle ones until started, so a restart always begins clean
            st_next.resp_reg.data = gen_run ? gen_byte : `TSFI_IDLE_BYTE;
        end else begin
            st_next.resp_reg.data = slot_req.data;
        end

        if (slot_req.valid && slot_req.frame_integrity) begin
            st_next.last_fi_delay_reg = fi_delay;
        end
        // saturate rather than wrap so a long run is not mistaken for a short one
        if (gen_advance && st_reg.subst_count_reg != 16'hffff) begin
            st_next.subst_count_reg = st_reg.subst_count_reg + 16'h0001;
        end
        if (!gen_run) begin
            st_next.subst_count_reg = 16'h0000;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{general_command_reg: `TSFI_REG_RESET,
                        test_command_reg: `TSFI_REG_RESET,
                        pattern_style_reg: `TSFI_REG_RESET,
                        pattern_user_byte_reg: `TSFI_REG_RESET,
                        highway_tx_enable_reg: 32'h0000_0000,
                        subst_count_reg: 16'h0000,
                        last_fi_delay_reg: 2'd0,
                        pready_reg: 1'b0,
                        pslverr_reg: 1'b0,
                        prdata_reg: 32'h0000_0000,
                        resp_reg: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata_reg;
    assign pready = st_reg.pready_reg;
    assign pslverr = st_reg.pslverr_reg;
    assign slot_resp = st_reg.resp_reg;

endmodule : tsfi_sched

// ### tsfi_sched_properties.sv
// Purpose: port-level checks of tsfi_sched
// Assumes: one-cycle slot answer, zero-wait APB
// Notes: bound to the block below the module
`timescale 1ns/1ns
module tsfi_sched_properties
    import tsfi_pkg::*;
#(
    parameter int NUM_HW = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tsfi_req_t slot_req,
    input wire tsfi_resp_t slot_resp
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic signed [13:0] diff;
    int tx_pos;
    int need;
    function automatic int st(logic [1:0] r);
        return r == 2'd0 ? 128 : (r == 2'd1 ? 64 : 32);
    endfunction : st
    // offsets are unsigned ticks, so widen before subtracting
    always_comb begin
        diff = $signed({2'b00, slot_req.tx_off}) - $signed({2'b00, slot_req.rx_off});
        tx_pos = slot_req.tx_slot * st(slot_req.tx_rate) + slot_req.tx_off;
        need = slot_req.rx_slot * st(slot_req.rx_rate) + slot_req.rx_off
            + 2 * st(slot_req.rx_rate) + 4 + slot_req.tx_hw;
    end
    sequence s_fi;
        slot_req.valid && slot_req.frame_integrity;
    endsequence
    sequence s_ll;
        slot_req.valid && !slot_req.frame_integrity;
    endsequence
    property p_fi_next;
        s_fi ##0 diff >= 128 |=> slot_resp.frame_delay == 2'd1;
    endproperty
    property p_fi_far;
        s_fi ##0 diff < -3968 |=> slot_resp.frame_delay == 2'd3;
    endproperty
    property p_fi_mid;
        s_fi ##0 (diff >= -3968 && diff < 128) |=> slot_resp.frame_delay == 2'd2;
    endproperty
    property p_ll_now;
        s_ll ##0 tx_pos >= need |=> slot_resp.frame_delay == 2'd0;
    endproperty
    property p_ll_late;
        s_ll ##0 tx_pos < need |=> slot_resp.frame_delay == 2'd1;
    endproperty
    property p_mark;
        slot_req.valid && slot_req.slot_source_mode == 3'b110 |=> slot_resp.pattern;
    endproperty
    property p_pass;
        slot_req.valid && slot_req.slot_source_mode != 3'b110 ##1 slot_resp.drive
            |-> slot_resp.data == $past(slot_req.data) && !slot_resp.pattern;
    endproperty
    property p_gate;
        slot_resp.valid && !slot_resp.drive |-> slot_resp.data == 8'h00;
    endproperty
    property p_valid;
        1 |=> slot_resp.valid == $past(slot_req.valid);
    endproperty
    property p_rdy;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    property p_err;
        pslverr |-> pready;
    endproperty
    a_fi_next: assert property (p_fi_next) else $error("fi delay not 1");
    a_fi_far: assert property (p_fi_far) else $error("fi delay not 3");
    a_fi_mid: assert property (p_fi_mid) else $error("fi delay not 2");
    a_ll_now: assert property (p_ll_now) else $error("ll not current");
    a_ll_late: assert property (p_ll_late) else $error("ll not next");
    a_mark: assert property (p_mark) else $error("marked slot not pattern");
    a_pass: assert property (p_pass) else $error("switched data altered");
    a_gate: assert property (p_gate) else $error("data while disabled");
    a_valid: assert property (p_valid) else $error("answer not one cycle later");
    a_rdy: assert property (p_rdy) else $error("pready not one cycle");
    a_err: assert property (p_err) else $error("pslverr without pready");
endmodule : tsfi_sched_properties

bind tsfi_sched tsfi_sched_properties #(.NUM_HW(NUM_HW)) u_props (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_req(slot_req), .slot_resp(slot_resp));

// ### tsfi_hw_model.sv
// Purpose: slot sequencer and highway sink beside tsfi_sched
// Assumes: bench raises go for each request cycle
// Notes: idle data toggles so stale bytes never look valid
`timescale 1ns/1ns
module tsfi_hw_model
    import tsfi_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic clr,
    input wire tsfi_req_t next_req,
    input wire tsfi_resp_t slot_resp,
    output tsfi_req_t slot_req,
    output tsfi_resp_t seen [0:15],
    output int n_seen
);
    initial begin
        slot_req = '0;
        n_seen = 0;
    end
    always @(posedge core_clk) begin
        if (go) begin
            slot_req <= next_req;
        end else begin
            slot_req.valid <= 1'b0;
            slot_req.data <= ~slot_req.data;
        end
        if (clr) begin
            n_seen <= 0;
        end else if (slot_resp.valid && n_seen < 16) begin
            seen[n_seen] <= slot_resp;
            n_seen <= n_seen + 1;
        end
    end
endmodule : tsfi_hw_model

// ### tsfi_sched_test.sv
// Purpose: directed bench for tsfi_sched
// Assumes: slots fed through tsfi_hw_model
// Notes: expectations worked out from offsets and codes
`timescale 1ns/1ns
module tsfi_sched_test
    import tsfi_pkg::*;
;
    logic core_clk, nrst, psel, penable, pwrite, go, clr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic pready, pslverr, err_val;
    logic [7:0] ev;
    logic [22:0] lf;
    tsfi_req_t slot_req, next_req, r;
    tsfi_resp_t slot_resp;
    tsfi_resp_t seen [0:15];
    tsfi_req_t q[$];
    int n_seen;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] fx [0:5] = '{8'h3c, 8'h00, 8'hff, 8'h55, 8'haa, 8'h0f};
    int ta [0:15] = '{0, 0, 0, 0, 0, 0, 7, 9, 11, 15, 20, 20, 23, 6, 10, 0};
    int tb [0:15] = '{0, 0, 0, 0, 0, 0, 6, 5, 9, 14, 17, 3, 18, 5, 7, 0};
    int fo_t [0:6] = '{128, 127, 0, 0, 0, 4095, 0};
    int fo_r [0:6] = '{0, 0, 0, 3968, 3969, 0, 4095};
    int fo_e [0:6] = '{1, 2, 2, 2, 3, 1, 3};
    int ll_s [0:7] = '{11, 10, 10, 10, 6, 5, 21, 20};
    int ll_r [0:7] = '{1, 1, 1, 1, 0, 0, 2, 2};
    int ll_o [0:7] = '{0, 0, 10, 9, 0, 0, 0, 0};
    int ll_e [0:7] = '{0, 1, 0, 1, 0, 1, 0, 1};
    tsfi_sched #(.NUM_HW(32)) u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slot_req(slot_req), .slot_resp(slot_resp));
    tsfi_hw_model u_model (.core_clk(core_clk), .go(go), .clr(clr), .next_req(next_req),
        .slot_resp(slot_resp), .slot_req(slot_req), .seen(seen), .n_seen(n_seen));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // pready looked at on rising edges; answer taken at the edge it is seen high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // no limit here: only the watchdog ends a hung transfer
        while (pready !== 1'b1) begin
            n++;
            @(posedge core_clk);
        end
        chk(n, 0, "apb wait states");
        rd_val = prdata;
        err_val = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk(err_val, e, "write error flag");
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 0);
        chk(err_val, 0, "read error flag");
        chk(rd_val, exp, "read data");
    endtask : rd
    task automatic run_slots();
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        foreach (q[k]) begin
            go <= 1'b1; next_req <= q[k];
            @(posedge core_clk);
        end
        go <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(n_seen, q.size(), "answer count");
    endtask : run_slots
    function automatic tsfi_req_t mk(int h, int s, logic [2:0] m, logic f, logic [7:0] d);
        tsfi_req_t x;
        x = '0;
        x.valid = 1'b1; x.tx_hw = 5'(h); x.tx_slot = 7'(s);
        x.slot_source_mode = m; x.frame_integrity = f; x.data = d;
        return x;
    endfunction : mk
    function automatic logic [22:0] adv(logic [22:0] s, int a, int b);
        for (int k = 0; k < 8; k++) s = {s[21:0], s[a-1] ^ s[b-1]};
        return s;
    endfunction : adv
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end
    initial begin
        {nrst, psel, penable, pwrite, go, clr} = '0;
        paddr = '0; pwdata = '0; next_req = '0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(16'h0000, 0);
        rd(16'h0024, 0);
        apb(1'b0, 16'h0100, 0);
        chk(err_val, 1, "unmapped read");
        wr(16'h0080, 32'h1, 1'b1);
        wr(16'h0024, 32'h30, 1'b0);
        rd(16'h0024, 32'h30);
        wr(16'h4038, 32'hff, 1'b0);
        rd(16'h4038, 32'h04);
        for (int g = 0; g < 2; g++) begin
            q = {mk(3, 1, 3'b000, 0, 8'h5a), mk(4, 2, 3'b000, 0, 8'h5a)};
            run_slots();
            chk(seen[0].data, g ? 8'h5a : 8'h00, "hw3 data");
            chk(seen[0].drive, g, "hw3 drive");
            chk({seen[1].drive, seen[1].data}, 0, "hw4 off");
            wr(16'h0000, 32'h1, 1'b0);
        end
        q = {};
        for (int k = 0; k < 7; k++) begin
            r = mk(3, k * 9, 3'b000, 1, 8'(k));
            r.rx_slot = 7'(100 - k * 7); r.tx_off = 12'(fo_t[k]); r.rx_off = 12'(fo_r[k]);
            q.push_back(r);
        end
        run_slots();
        foreach (fo_e[k]) chk(seen[k].frame_delay, fo_e[k], "fi frame");
        foreach (fo_e[k]) chk({seen[k].tx_hw, seen[k].tx_slot}, {5'd3, 7'(k * 9)}, "slot id");
        rd(16'h0080, 32'h3);
        q = {};
        for (int k = 0; k < 8; k++) begin
            r = mk(6, ll_s[k], 3'b000, 0, 8'h00);
            r.tx_rate = 2'(ll_r[k]); r.tx_off = 12'(ll_o[k]);
            r.rx_slot = 7'd5; r.rx_rate = 2'd1; r.rx_off = 12'd192;
            q.push_back(r);
        end
        run_slots();
        foreach (ll_e[k]) chk(seen[k].frame_delay, ll_e[k], "ll frame");
        wr(16'h0048, 32'h3c, 1'b0);
        for (int c = 0; c < 16; c++) begin
            wr(16'h0028, 32'(c << 4), 1'b0);
            wr(16'h0024, 32'ha0, 1'b0);
            // one highway, one contiguous run, cleared before each restart
            q = {mk(3, 10, 3'b110, 0, 8'h11), mk(3, 5, 3'b000, 0, 8'h77),
                mk(3, 11, 3'b110, 0, 8'h22), mk(3, 12, 3'b110, 0, 8'h33)};
            run_slots();
            lf = 23'h7fffff;
            for (int k = 0; k < 4; k++) begin
                if (k == 1) ev = 8'h77;
                else if (c < 6) ev = fx[c];
                else if (c == 15) ev = 8'h00;
                else begin
                    ev = lf[7:0];
                    lf = adv(lf, ta[c], tb[c]);
                end
                chk(seen[k].data, ev, "slot byte");
                chk(seen[k].pattern, k != 1, "pattern flag");
            end
            rd(16'h0084, 32'h3);
            wr(16'h0024, 32'h0, 1'b0);
        end
        // marked slot while the generator is stopped sends idle ones
        q = {mk(3, 10, 3'b110, 0, 8'h11)};
        run_slots();
        chk(seen[0].data, 8'hff, "idle byte");
        tally_and_finish();
    end
endmodule : tsfi_sched_test
